// *** cfg_status_header.v ***
// Configuration status, identity, cache line and latency registers of one bridge function
`include "cfg_status_defs.vh"
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Address or data parity error sets bit 15
// - Enabled system error report sets bit 14
// - Own master cycle master-aborted sets bit 13
// - Own master cycle target-aborted sets bit 12
// - Our target abort sets bit 11
// - Bits 10:9 fixed 01, medium decode
// - Bit 8: PERR, we master, response on
// - Writing one clears each error flag
// - Writing zero leaves a flag alone
// - Parity response disabled keeps data parity out of bit 8; bit 15 still sets
// - Bit 7 reads zero, not writable
// - Bit 6 hardwired zero
// - Bit 5 hardwired zero
// - Bit 4 always reads one
// - Bits 3:0 read zero
// - Revision register fixed, writes ignored
// - Class code fixed at bridge card-bus
// - Latency counts from zero at FRAME
// - Expired and GNT removed (GNT_N high) ends master cycle
module cfg_status_header
#(
    parameter [7:0] REVISION = `REVISION_CODE // Arbitrary value
)
(
    // Clock and reset
    input  wire        CLK_SYS,
    input  wire        NRST,
    // Configuration access, byte addressed, one dword lane set
    input  wire        CFG_WR,
    input  wire        CFG_RD,
    input  wire [7:0]  CFG_ADDR,
    input  wire [3:0]  CFG_BE,
    input  wire [31:0] CFG_WDATA,
    output reg  [31:0] CFG_RDATA,
    // Command register enables
    input  wire        SERR_ENABLE,
    input  wire        PARITY_RESPONSE_ENABLE,
    // Bus events
    input  wire        ADDR_PARITY_ERR,
    input  wire        DATA_PARITY_ERR,
    input  wire        PERR_SEEN,
    input  wire        SERR_DRIVEN,
    input  wire        MASTER_ACTIVE,
    input  wire        MASTER_ABORT,
    input  wire        TARGET_ABORT_RX,
    input  wire        TARGET_ABORT_TX,
    // Master cycle timing
    input  wire        FRAME_START,
    input  wire        GNT_N,
    output reg         MASTER_END_REQ,
    // Programmed values
    output reg  [7:0]  CACHE_LINE_SIZE,
    output reg  [7:0]  LATENCY_LIMIT
);

    wire        parity_error_seen;
    wire        system_error_signalled;
    wire        master_abort_received;
    wire        target_abort_received;
    wire        target_abort_signalled;
    wire        master_data_parity_flag;
    wire        lat_expired;
    wire [7:0]  lat_count;
    wire [15:0] status_clr;
    wire [15:0] status_value;
    wire        hit_dw0;
    wire        hit_dw2;
    wire        hit_dw3;
    reg  [31:0] next_rdata;

    localparam [5:0] DW_CMD_STATUS = 6'h01;
    localparam [5:0] DW_REV_CLASS  = 6'h02;
    localparam [5:0] DW_CACHE_LAT  = 6'h03;

    assign hit_dw0 = (CFG_ADDR[7:2] == DW_CMD_STATUS);
    assign hit_dw2 = (CFG_ADDR[7:2] == DW_REV_CLASS);
    assign hit_dw3 = (CFG_ADDR[7:2] == DW_CACHE_LAT);

    // Status lives in upper half of dword 04h; only ones clear
    assign status_clr = (CFG_WR && hit_dw0) ?
        ({(CFG_BE[3] ? CFG_WDATA[31:24] : 8'h00),
          (CFG_BE[2] ? CFG_WDATA[23:16] : 8'h00)} & `STATUS_STICKY_MASK) :
        16'h0000;

    sticky_flag u_par
    (
        .CLK_SYS (CLK_SYS),
        .NRST    (NRST),
        .set_evt (ADDR_PARITY_ERR | DATA_PARITY_ERR),
        .clr_evt (status_clr[`BIT_PARITY_SEEN]),
        .flag    (parity_error_seen)
    );

    sticky_flag u_serr
    (
        .CLK_SYS (CLK_SYS),
        .NRST    (NRST),
        .set_evt (SERR_ENABLE & SERR_DRIVEN),
        .clr_evt (status_clr[`BIT_SYSERR_SIG]),
        .flag    (system_error_signalled)
    );

    sticky_flag u_mab
    (
        .CLK_SYS (CLK_SYS),
        .NRST    (NRST),
        .set_evt (MASTER_ACTIVE & MASTER_ABORT),
        .clr_evt (status_clr[`BIT_MASTER_ABORT_RECEIVED_RX]),
        .flag    (master_abort_received)
    );

    sticky_flag u_tabr
    (
        .CLK_SYS (CLK_SYS),
        .NRST    (NRST),
        .set_evt (MASTER_ACTIVE & TARGET_ABORT_RX),
        .clr_evt (status_clr[`BIT_TABORT_RX]),
        .flag    (target_abort_received)
    );

    sticky_flag u_tabs
    (
        .CLK_SYS (CLK_SYS),
        .NRST    (NRST),
        .set_evt (TARGET_ABORT_TX),
        .clr_evt (status_clr[`BIT_TABORT_SIG]),
        .flag    (target_abort_signalled)
    );

    // Disabled response masks the event entirely, not just the report
    sticky_flag u_mdp
    (
        .CLK_SYS (CLK_SYS),
        .NRST    (NRST),
        .set_evt (DATA_PARITY_ERR & PERR_SEEN & MASTER_ACTIVE & PARITY_RESPONSE_ENABLE),
        .clr_evt (status_clr[`BIT_MDPAR]),
        .flag    (master_data_parity_flag)
    );

    // Fixed bits: 10:9=01, 7..5=0, 4=1, 3:0=0
    assign status_value = `STATUS_FIXED |
        {parity_error_seen, system_error_signalled, master_abort_received,
         target_abort_received, target_abort_signalled, 2'b00,
         master_data_parity_flag, 8'h00};

    latency_counter
    #(
        .WIDTH (8)
    )
    u_lat
    (
        .CLK_SYS     (CLK_SYS),
        .NRST        (NRST),
        .frame_start (FRAME_START),
        .master_busy (MASTER_ACTIVE),
        .limit       (LATENCY_LIMIT),
        .expired     (lat_expired),
        .count       (lat_count)
    );

    // Writable bytes of dword 0Ch
    always @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            CACHE_LINE_SIZE <= `CACHE_LINE_RESET;
            LATENCY_LIMIT   <= `LATENCY_RESET;
        end
        else if (CFG_WR && hit_dw3)
        begin
            if (CFG_BE[0])
                CACHE_LINE_SIZE <= CFG_WDATA[7:0];
            if (CFG_BE[1])
                LATENCY_LIMIT <= CFG_WDATA[15:8];
        end
    end

    // Revision and class have no write path at all
    always @*
    begin
        next_rdata = 32'h0000_0000;
        if (hit_dw0)
            next_rdata = {status_value, 16'h0000};
        else if (hit_dw2)
            next_rdata = {`CLASS_CODE, REVISION};
        else if (hit_dw3)
            next_rdata = {16'h0000, LATENCY_LIMIT, CACHE_LINE_SIZE};
    end

    always @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            CFG_RDATA      <= 32'h0000_0000;
            MASTER_END_REQ <= 1'b0;
        end
        else
        begin
            if (CFG_RD)
                CFG_RDATA <= next_rdata;
            // Ends only after grant removed, so a granted master may overrun
            MASTER_END_REQ <= MASTER_ACTIVE & lat_expired & GNT_N;
        end
    end

endmodule // cfg_status_header

`default_nettype wire

// *** cfg_status_defs.vh ***
// Offsets, field positions, reset values and fixed codes of the status header block
`ifndef CFG_STATUS_DEFS_VH
`define CFG_STATUS_DEFS_VH

`define OFS_STATUS          8'h06
`define OFS_REVISION        8'h08
`define OFS_CLASS           8'h09
`define OFS_CACHE_LINE      8'h0C
`define OFS_LATENCY         8'h0D

`define BIT_PARITY_SEEN     15
`define BIT_SYSERR_SIG      14
`define BIT_MASTER_ABORT_RECEIVED_RX       13
`define BIT_TABORT_RX       12
`define BIT_TABORT_SIG      11
`define BIT_MDPAR           8

`define STATUS_FIXED        16'h0210
`define STATUS_STICKY_MASK  16'hF900
`define CLASS_CODE          24'h0607_00
`define REVISION_CODE       8'h5A
`define CACHE_LINE_RESET    8'h00
`define LATENCY_RESET       8'h00

`endif

// *** sticky_flag.v ***
// One write-one-to-clear status flag where a set wins over a clear
`timescale 1ns/1ps
`default_nettype none

module sticky_flag
(
    // Clock and reset
    input  wire CLK_SYS,
    input  wire NRST,
    // Control
    input  wire set_evt,
    input  wire clr_evt,
    // State
    output reg  flag
);

    always @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
            flag <= 1'b0;
        else if (set_evt)
            flag <= 1'b1;
        else if (clr_evt)
            flag <= 1'b0;
    end

endmodule // sticky_flag

`default_nettype wire

// *** latency_counter.v ***
// Master latency counter started by FRAME and held once expired
`timescale 1ns/1ps
`default_nettype none

module latency_counter
#(
    parameter WIDTH = 8
)
(
    // Clock and reset
    input  wire             CLK_SYS,
    input  wire             NRST,
    // Master cycle
    input  wire             frame_start,
    input  wire             master_busy,
    input  wire [WIDTH-1:0] limit,
    // Result
    output reg              expired,
    output reg  [WIDTH-1:0] count
);

    always @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            count   <= {WIDTH{1'b0}};
            expired <= 1'b0;
        end
        else if (frame_start)
        begin
            count   <= {WIDTH{1'b0}};
            expired <= (limit == {WIDTH{1'b0}});
        end
        else if (master_busy && !expired)
        begin
            count   <= count + 1'b1;
            expired <= (count + 1'b1 >= limit);
        end
        else if (!master_busy)
            expired <= 1'b0;
    end

endmodule // latency_counter

`default_nettype wire

// *** cfg_host.sv ***
// Configuration host model issuing single dword reads and writes
`timescale 1ns/1ps
`default_nettype none
module cfg_host
(
    // Clock
    input  wire logic        CLK_SYS,
    // Configuration access
    output var  logic        CFG_WR,
    output var  logic        CFG_RD,
    output var  logic [7:0]  CFG_ADDR,
    output var  logic [3:0]  CFG_BE,
    output var  logic [31:0] CFG_WDATA,
    input  wire logic [31:0] CFG_RDATA
);
    initial {CFG_WR, CFG_RD, CFG_ADDR, CFG_BE, CFG_WDATA} = '0;
    // Idle lines flip so a stale value never looks held
    task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(negedge CLK_SYS);
        {CFG_WR, CFG_ADDR, CFG_BE, CFG_WDATA} = {1'b1, a, b, d};
        @(negedge CLK_SYS);
        {CFG_WR, CFG_ADDR, CFG_BE, CFG_WDATA} = {1'b0, ~a, 4'h0, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge CLK_SYS);
        {CFG_RD, CFG_ADDR} = {1'b1, a};
        @(negedge CLK_SYS);
        {CFG_RD, CFG_ADDR} = {1'b0, ~a};
        d = CFG_RDATA;
    endtask
endmodule // cfg_host
`default_nettype wire

// *** status_checker.sv ***
// Port assertions for the status header block
`timescale 1ns/1ps
`default_nettype none
module status_checker
(
    input wire logic        CLK_SYS, NRST, CFG_WR, CFG_RD, SERR_ENABLE, SERR_DRIVEN,
    input wire logic        PARITY_RESPONSE_ENABLE, ADDR_PARITY_ERR, DATA_PARITY_ERR,
    input wire logic        PERR_SEEN, MASTER_ACTIVE, TARGET_ABORT_TX, FRAME_START,
    input wire logic        GNT_N, MASTER_END_REQ, MASTER_ABORT, TARGET_ABORT_RX,
    input wire logic [7:0]  CFG_ADDR, CACHE_LINE_SIZE, LATENCY_LIMIT,
    input wire logic [3:0]  CFG_BE,
    input wire logic [31:0] CFG_WDATA, CFG_RDATA
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // Events land two edges before the read; a write between could clear
    sequence stat_rd;
        CFG_RD && CFG_ADDR[7:2] == 6'h01 && !$past(CFG_WR);
    endsequence
    fixed_bits_a:
        assert property (stat_rd |=> (CFG_RDATA[31:16] & 16'h06FF) == 16'h0210)
        else $error("fixed status bits wrong");
    class_code_a:
        assert property (CFG_RD && CFG_ADDR[7:2] == 6'h02 |=> CFG_RDATA[31:8] == 24'h06_0700)
        else $error("class code wrong");
    parity_flag_a:
        assert property (stat_rd ##0 $past(ADDR_PARITY_ERR, 2) |=> CFG_RDATA[31])
        else $error("parity flag missing");
    serr_flag_a:
        assert property (stat_rd ##0 $past(SERR_DRIVEN && SERR_ENABLE, 2) |=> CFG_RDATA[30])
        else $error("system error flag missing");
    master_abort_received_flag_a:
        assert property (stat_rd ##0 $past(MASTER_ABORT && MASTER_ACTIVE, 2) |=> CFG_RDATA[29])
        else $error("master abort flag missing");
    tabort_rx_a:
        assert property (stat_rd ##0 $past(TARGET_ABORT_RX && MASTER_ACTIVE, 2) |=> CFG_RDATA[28])
        else $error("received target abort flag missing");
    tabort_flag_a:
        assert property (stat_rd ##0 $past(TARGET_ABORT_TX, 2) |=> CFG_RDATA[27])
        else $error("target abort flag missing");
    dpar_flag_a:
        assert property (stat_rd ##0 $past(DATA_PARITY_ERR && PERR_SEEN && MASTER_ACTIVE
            && PARITY_RESPONSE_ENABLE, 2) |=> CFG_RDATA[24]) else $error("data parity flag missing");
    end_req_a:
        assert property (MASTER_END_REQ |-> $past(GNT_N && MASTER_ACTIVE))
        else $error("end request without cause");
    latency_restart_a:
        assert property (FRAME_START && LATENCY_LIMIT > 8'h02 |-> ##2 !MASTER_END_REQ)
        else $error("latency count not restarted");
    line_write_a:
        assert property (CFG_WR && CFG_ADDR[7:2] == 6'h03 && CFG_BE[1:0] == 2'b11
            |=> {LATENCY_LIMIT, CACHE_LINE_SIZE} == $past(CFG_WDATA[15:0]))
        else $error("line or latency write lost");
endmodule // status_checker
bind cfg_status_header status_checker status_checker_i (.*);
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the status header block
`include "cfg_status_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        CLK_SYS, NRST, CFG_WR, CFG_RD, SERR_ENABLE, PARITY_RESPONSE_ENABLE, PERR_SEEN;
    logic        ADDR_PARITY_ERR, DATA_PARITY_ERR, SERR_DRIVEN, MASTER_ACTIVE, MASTER_ABORT;
    logic        TARGET_ABORT_RX, TARGET_ABORT_TX, FRAME_START, GNT_N, MASTER_END_REQ;
    logic [7:0]  CFG_ADDR, CACHE_LINE_SIZE, LATENCY_LIMIT;
    logic [3:0]  CFG_BE;
    logic [31:0] CFG_WDATA, CFG_RDATA, rd_val;
    int          bad_count = 0;
    int          tests_run = 0;
    cfg_status_header cfg_status_header_i (.*);
    cfg_host          cfg_host_i (.*);
    initial
    begin
        CLK_SYS = 1'b0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        cfg_host_i.rd(a, rd_val);
        chk(rd_val, exp);
    endtask
    task automatic pulse(input logic [6:0] v);
        @(negedge CLK_SYS);
        {ADDR_PARITY_ERR, DATA_PARITY_ERR, PERR_SEEN, SERR_DRIVEN, MASTER_ABORT,
            TARGET_ABORT_RX, TARGET_ABORT_TX} = v;
        @(negedge CLK_SYS);
        {ADDR_PARITY_ERR, DATA_PARITY_ERR, PERR_SEEN, SERR_DRIVEN, MASTER_ABORT,
            TARGET_ABORT_RX, TARGET_ABORT_TX} = 7'h00;
    endtask
    task automatic reset_values;
        chk({16'h0000, LATENCY_LIMIT, CACHE_LINE_SIZE}, 32'h0000_0000);
        rd_chk(8'h40, 32'h0000_0000);
        cfg_host_i.wr(8'h08, 4'hF, 32'hFFFF_FFFF);
        cfg_host_i.wr(8'h04, 4'hC, 32'h06FF_0000);
        rd_chk(8'h08, {24'h06_0700, `REVISION_CODE});
        rd_chk(8'h04, 32'h0210_0000);
    endtask
    task automatic error_flags;
        logic [6:0]  ev [6] = '{7'h40, 7'h30, 7'h08, 7'h04, 7'h02, 7'h01};
        logic [15:0] fl [6] = '{16'h8000, 16'h8100, 16'h4000, 16'h2000, 16'h1000, 16'h0800};
        logic [15:0] acc;
        acc = 16'h0000;
        for (int i = 0; i < 6; i++)
        begin
            pulse(ev[i]);
            acc = acc | fl[i];
            rd_chk(8'h04, {16'h0210 | acc, 16'h0000});
        end
        // High lanes only, so the low word must be ignored
        for (int i = 5; i >= 0; i--)
        begin
            cfg_host_i.wr(8'h04, 4'hC, {fl[i], 16'hFFFF});
            acc = acc & ~fl[i];
            rd_chk(8'h04, {16'h0210 | acc, 16'h0000});
        end
        PARITY_RESPONSE_ENABLE = 1'b0;
        pulse(7'h30);
        rd_chk(8'h04, 32'h8210_0000);
        PARITY_RESPONSE_ENABLE = 1'b1;
        // Aborts outside our own master cycle must not count
        MASTER_ACTIVE = 1'b0;
        pulse(7'h06);
        rd_chk(8'h04, 32'h8210_0000);
        MASTER_ACTIVE = 1'b1;
        SERR_ENABLE = 1'b0;
        pulse(7'h08);
        rd_chk(8'h04, 32'h8210_0000);
        SERR_ENABLE = 1'b1;
    endtask
    task automatic latency;
        int n;
        cfg_host_i.wr(8'h0C, 4'h3, 32'h0000_0520);
        chk({16'h0000, LATENCY_LIMIT, CACHE_LINE_SIZE}, 32'h0000_0520);
        for (int k = 0; k < 2; k++)
        begin
            GNT_N = 1'b1;
            FRAME_START = 1'b1;
            @(negedge CLK_SYS);
            FRAME_START = 1'b0;
            @(negedge CLK_SYS);
            chk({31'h0, MASTER_END_REQ}, 32'h0);
            n = 0;
            while (MASTER_END_REQ !== 1'b1 && n < 12)
            begin
                @(negedge CLK_SYS);
                n++;
            end
            chk(n, 32'd5);
            repeat (3) @(negedge CLK_SYS);
            chk({31'h0, MASTER_END_REQ}, 32'h1);
            GNT_N = 1'b0;
            repeat (2) @(negedge CLK_SYS);
            chk({31'h0, MASTER_END_REQ}, 32'h0);
        end
    endtask
    initial
    begin
        NRST = 1'b0;
        {SERR_ENABLE, PARITY_RESPONSE_ENABLE, MASTER_ACTIVE} = 3'b111;
        {ADDR_PARITY_ERR, DATA_PARITY_ERR, PERR_SEEN, SERR_DRIVEN, MASTER_ABORT} = 5'h00;
        {TARGET_ABORT_RX, TARGET_ABORT_TX, FRAME_START, GNT_N} = 4'h0;
        repeat (6) @(negedge CLK_SYS);
        NRST = 1'b1;
        reset_values;
        error_flags;
        latency;
        end_of_test;
    end
    // Run needs about 100 cycles; this allows far more
    initial
    begin
        #100000;
        bad_count++;
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
